// ===== sfb_pkg.sv
package sfb_pkg;

  // ****************************************
  // array organisation
  // ****************************************
  localparam int WIDE_DATA_W   = 32'h24;
  localparam int WIDE_ADDR_W   = 32'h12;
  localparam int NARROW_DATA_W = 32'h12;
  localparam int NARROW_ADDR_W = 32'h13;
  localparam int LANE_W        = 32'h9;
  localparam int BURST_W       = 32'h2;

  // ****************************************
  // write buffer and input synchroniser
  // ****************************************
  localparam int         BUF_DEPTH   = 32'h2;
  localparam int         BUF_CNT_W   = 32'h2;
  localparam logic [1:0] BUF_FULL    = 2'h2;
  localparam logic [1:0] BUF_EMPTY   = 2'h0;
  localparam int         SYNC_STAGES = 32'h2;

  // rated ceiling of the fastest grade; the 50 MHz system clock stays below it
  localparam int MAX_BUS_MHZ = 32'h85;
  localparam int SYS_CLK_MHZ = 32'h32;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic       SYNC_RST      = 1'h0;

  // ****************************************
  // data phase of the cycle started at the last qualified edge
  // ****************************************
  typedef enum logic [1:0]
  {
    CYC_IDLE  = 2'b00,
    CYC_READ  = 2'b01,
    CYC_WRITE = 2'b10
  } sfb_cyc_t;

endpackage

// ===== sfb_write_buffer.sv
`timescale 1ns/10ps

module sfb_write_buffer
#(
  parameter int W = 8
)
(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  logic [W-1:0]                   slot_r [sfb_pkg::BUF_DEPTH];
  logic                           wr_ptr_r;
  logic                           rd_ptr_r;
  logic [sfb_pkg::BUF_CNT_W-1:0]  count_r;
  logic                           push;
  logic                           pop;

  assign in_ready  = (count_r != sfb_pkg::BUF_FULL);
  assign out_valid = (count_r != sfb_pkg::BUF_EMPTY);
  assign out_data  = slot_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge sys_clk)
  begin
    if (push)
    begin
      slot_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      wr_ptr_r <= 1'h0;
      rd_ptr_r <= 1'h0;
      count_r  <= sfb_pkg::BUF_EMPTY;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop)
      begin
        rd_ptr_r <= ~rd_ptr_r;
      end
      if (push & ~pop)
      begin
        count_r <= count_r + 2'h1;
      end
      else if (pop & ~push)
      begin
        count_r <= count_r - 2'h1;
      end
    end
  end

endmodule

// ===== sfb_sram_port.sv
`timescale 1ns/10ps

// What this block does
// RULE1: 256Kx36 or 512Kx18 array by variant
// RULE2: all synchronous inputs captured on rising edge
// RULE3: deasserted qualifier freezes every state element; the sleep synchroniser still advances on every edge
// RULE4: back-to-back reads and writes, any mix
// RULE5: no dead cycle at bus turnaround
// RULE6: zero wait states up to rated clock
// RULE7: write strobe plus per-lane selects update lanes
// RULE8: writes complete internally, self-timed
// RULE9: cycle starts only with all three selects
// RULE10: output enable gates drivers asynchronously
// RULE11: drivers off during write data phase
// RULE12: drivers turned around by internal timing
// RULE13: flow-through reads, no output register
// RULE14: two low address bits burst linear/interleaved
// RULE15: sleep input or deselect powers down
// RULE16: static input picks linear or interleaved
// RULE17: advance/load picks new address or burst step

module sfb_sram_port
#(
  parameter bit NARROW_VARIANT = 1'b0
)
(
  sys_clk,
  reset,
  address_upper,
  burst_address_bit1,
  burst_address_bit0,
  advance_or_load,
  write_enable_n,
  byte_lane_write_select_n,
  chip_select_first_n,
  chip_select_second,
  chip_select_third_n,
  clock_qualify_n,
  output_enable_n,
  sleep_request,
  burst_order_interleaved,
  dq_in,
  dq_out,
  dq_oe,
  write_buffer_ready,
  power_down
);

  localparam int DATA_W = NARROW_VARIANT ? sfb_pkg::NARROW_DATA_W : sfb_pkg::WIDE_DATA_W;
  localparam int ADDR_W = NARROW_VARIANT ? sfb_pkg::NARROW_ADDR_W : sfb_pkg::WIDE_ADDR_W;
  localparam int LANES  = DATA_W / sfb_pkg::LANE_W;
  localparam int DEPTH  = 1 << ADDR_W;
  localparam int BUF_W  = ADDR_W + LANES + DATA_W;
  localparam int LW     = sfb_pkg::LANE_W;

  input  wire logic                  sys_clk;
  input  wire logic                  reset;
  input  wire logic [ADDR_W-3:0]     address_upper;
  input  wire logic                  burst_address_bit1;
  input  wire logic                  burst_address_bit0;
  input  wire logic                  advance_or_load;
  input  wire logic                  write_enable_n;
  input  wire logic [LANES-1:0]      byte_lane_write_select_n;
  input  wire logic                  chip_select_first_n;
  input  wire logic                  chip_select_second;
  input  wire logic                  chip_select_third_n;
  input  wire logic                  clock_qualify_n;
  input  wire logic                  output_enable_n;
  input  wire logic                  sleep_request;
  input  wire logic                  burst_order_interleaved;
  input  wire logic [DATA_W-1:0]     dq_in;
  output logic      [DATA_W-1:0]     dq_out;
  output logic                       dq_oe;
  output logic                       write_buffer_ready;
  output logic                       power_down;

  // ****************************************
  // burst sequencing and chip select decode
  // ****************************************
  function automatic logic [1:0] burst_low
  (
    input logic [1:0] base,
    input logic [1:0] count,
    input logic       interleaved
  );
    burst_low = interleaved ? (base ^ count) : (base + count);
  endfunction

  function automatic logic cs_all
  (
    input logic first_n,
    input logic second,
    input logic third_n
  );
    cs_all = ~first_n & second & ~third_n;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [DATA_W-1:0]       mem_r [DEPTH];
  sfb_pkg::sfb_cyc_t       cyc_r;
  sfb_pkg::sfb_cyc_t       cyc_nxt;
  logic [ADDR_W-1:0]       addr_r;
  logic [ADDR_W-1:0]       addr_nxt;
  logic [1:0]              base_lo_r;
  logic [1:0]              count_r;
  logic [1:0]              count_nxt;
  logic [LANES-1:0]        lanes_r;
  logic [LANES-1:0]        lanes_nxt;
  logic                    sleep_meta_r;
  logic                    sleep_r;
  logic                    qual;
  logic                    start;
  logic                    step;
  logic                    buf_in_valid;
  logic                    buf_in_ready;
  logic [BUF_W-1:0]        buf_in_data;
  logic                    buf_out_valid;
  logic                    buf_out_ready;
  logic [BUF_W-1:0]        buf_out_data;
  logic [ADDR_W-1:0]       hd_addr;
  logic [LANES-1:0]        hd_lanes;
  logic [DATA_W-1:0]       hd_data;
  logic                    byp_hit;
  logic [DATA_W-1:0]       rd_word;

  // sleep is asynchronous to the bus clock
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      sleep_meta_r <= sfb_pkg::SYNC_RST;
      sleep_r      <= sfb_pkg::SYNC_RST;
    end
    else
    begin
      sleep_meta_r <= sleep_request;
      sleep_r      <= sleep_meta_r;
    end
  end

  // ****************************************
  // command decode
  // ****************************************
  assign qual = ~clock_qualify_n; // RULE3
  // a full buffer or sleep refuses the start; the cycle then counts as a deselect
  assign start = ~advance_or_load & ~sleep_r & buf_in_ready
                 & cs_all(chip_select_first_n, chip_select_second, chip_select_third_n); // RULE9 RULE17
  assign step  = advance_or_load & (cyc_r != sfb_pkg::CYC_IDLE) & ~sleep_r; // RULE17

  always_comb
  begin
    cyc_nxt   = sfb_pkg::CYC_IDLE;
    addr_nxt  = addr_r;
    count_nxt = count_r;
    lanes_nxt = lanes_r;
    if (start)
    begin
      cyc_nxt   = write_enable_n ? sfb_pkg::CYC_READ : sfb_pkg::CYC_WRITE; // RULE4 RULE5
      addr_nxt  = {address_upper, burst_address_bit1, burst_address_bit0};
      count_nxt = sfb_pkg::BURST_CNT_RST;
      lanes_nxt = ~byte_lane_write_select_n; // RULE7
    end
    else if (step)
    begin
      // a burst step keeps the operation of the loaded cycle and takes fresh lane selects
      cyc_nxt   = cyc_r;
      count_nxt = count_r + 2'h1;
      addr_nxt  = {addr_r[ADDR_W-1:2], burst_low(base_lo_r, count_r + 2'h1, burst_order_interleaved)}; // RULE14 RULE16
      lanes_nxt = ~byte_lane_write_select_n; // RULE7
    end
  end

  // input registers advance only on qualified edges
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      cyc_r     <= sfb_pkg::CYC_IDLE;
      addr_r    <= '0;
      base_lo_r <= sfb_pkg::BURST_CNT_RST;
      count_r   <= sfb_pkg::BURST_CNT_RST;
      lanes_r   <= '0;
    end
    else if (qual) // RULE2 RULE3
    begin
      cyc_r   <= cyc_nxt;
      addr_r  <= addr_nxt;
      count_r <= count_nxt;
      lanes_r <= lanes_nxt;
      if (start)
      begin
        base_lo_r <= {burst_address_bit1, burst_address_bit0}; // RULE14
      end
    end
  end

  // ****************************************
  // self-timed write path
  // ****************************************
  // write data is taken at the edge closing the data phase and queued,
  // so the array update never needs a strobe from the controller
  assign buf_in_valid  = qual & (cyc_r == sfb_pkg::CYC_WRITE); // RULE2 RULE8
  assign buf_in_data   = {addr_r, lanes_r, dq_in};
  // draining stops while asleep; a write already in flight still lands in the buffer
  assign buf_out_ready = qual & ~sleep_r; // RULE8
  assign write_buffer_ready = buf_in_ready;

  sfb_write_buffer
  #(
    .W (BUF_W)
  )
  u_wbuf
  (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  assign hd_addr  = buf_out_data[BUF_W-1 -: ADDR_W];
  assign hd_lanes = buf_out_data[DATA_W+LANES-1 -: LANES];
  assign hd_data  = buf_out_data[DATA_W-1:0];

  always_ff @(posedge sys_clk)
  begin
    if (buf_out_valid & buf_out_ready)
    begin
      for (int l = 0; l < LANES; l++)
      begin
        if (hd_lanes[l])
        begin
          mem_r[hd_addr][l*LW +: LW] <= hd_data[l*LW +: LW]; // RULE1 RULE7 RULE8
        end
      end
    end
  end

  // ****************************************
  // flow-through read path
  // ****************************************
  // the queued write is not yet in the array; forwarding it keeps write-then-read
  // to one address free of a dead cycle
  assign byp_hit = buf_out_valid & (hd_addr == addr_r); // RULE5

  generate
    for (genvar g = 0; g < LANES; g++)
    begin : g_lane
      assign rd_word[g*LW +: LW] = (byp_hit & hd_lanes[g]) ? hd_data[g*LW +: LW] : mem_r[addr_r][g*LW +: LW];
    end
  endgenerate

  // combinational on purpose: data must leave in the cycle of its address
  assign dq_out = rd_word; // RULE13 RULE6
  assign dq_oe  = ~output_enable_n & (cyc_r == sfb_pkg::CYC_READ); // RULE10 RULE11 RULE12

  assign power_down = sleep_r | (cyc_r == sfb_pkg::CYC_IDLE); // RULE15

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  write_phase_quiet_a: assert property ((cyc_r == sfb_pkg::CYC_WRITE) |-> !dq_oe) // RULE11
    else $error("drivers on during write data phase");

  async_oe_a: assert property (output_enable_n |-> !dq_oe) // RULE10
    else $error("drivers on with output enable deasserted");

  read_drive_a: assert property ((cyc_r == sfb_pkg::CYC_READ) && !output_enable_n && !byp_hit // RULE13
    |-> dq_oe && dq_out == mem_r[addr_r])
    else $error("read data phase not driven from the array");

  suspend_hold_a: assert property (clock_qualify_n |=> $stable(cyc_r) && $stable(addr_r) && $stable(count_r)) // RULE3
    else $error("state moved while clock unqualified");

  load_write_a: assert property (qual && start && !write_enable_n |=> cyc_r == sfb_pkg::CYC_WRITE ##1 1'b1) // RULE4
    else $error("write load not taken");

  deselect_idle_a: assert property (qual && !advance_or_load
    && !cs_all(chip_select_first_n, chip_select_second, chip_select_third_n) |=> cyc_r == sfb_pkg::CYC_IDLE) // RULE9
    else $error("cycle started without all selects");

  burst_linear_a: assert property (qual && step && !burst_order_interleaved
    |=> addr_r[1:0] == $past(addr_r[1:0]) + 2'h1) // RULE14
    else $error("linear burst step wrong");

  burst_inter_a: assert property ((cyc_r != sfb_pkg::CYC_IDLE) && burst_order_interleaved && $past(burst_order_interleaved)
    && $past(qual) && $past(step) |-> addr_r[1:0] == (base_lo_r ^ count_r)) // RULE14
    else $error("interleaved burst step wrong");

  no_loss_a: assert property (buf_in_valid |-> buf_in_ready) // RULE4
    else $error("write data dropped");

  back_to_back_a: assert property (qual && start && cyc_r == sfb_pkg::CYC_WRITE && write_enable_n
    |=> cyc_r == sfb_pkg::CYC_READ) // RULE5
    else $error("turnaround inserted a dead cycle");

  // an unqualified edge legally keeps the cycle, so only qualified edges are judged
  sleep_down_a: assert property (sleep_r && qual |-> power_down ##1 (!sleep_r || cyc_r == sfb_pkg::CYC_IDLE)) // RULE15
    else $error("not powered down while asleep");

  load_read_a: assert property (qual && start && write_enable_n |=> cyc_r == sfb_pkg::CYC_READ) // RULE4
    else $error("read load not taken");

  read_write_turn_a: assert property (qual && start && cyc_r == sfb_pkg::CYC_READ && !write_enable_n // RULE5
    |=> cyc_r == sfb_pkg::CYC_WRITE && !dq_oe)
    else $error("read to write turnaround inserted a dead cycle");

  load_addr_a: assert property (qual && start |=> addr_r[ADDR_W-1:2] == $past(address_upper) // RULE2
    && addr_r[1] == $past(burst_address_bit1) && addr_r[0] == $past(burst_address_bit0))
    else $error("load address not captured");

  lane_select_a: assert property (qual && (start || step) // RULE7
    |=> lanes_r == ~$past(byte_lane_write_select_n))
    else $error("lane selects not captured");

  write_push_a: assert property (qual && cyc_r == sfb_pkg::CYC_WRITE |=> buf_out_valid) // RULE8
    else $error("write data not queued");

  full_refuse_a: assert property (qual && !advance_or_load && !buf_in_ready // RULE8
    |=> cyc_r == sfb_pkg::CYC_IDLE)
    else $error("cycle started with the write buffer full");

  sleep_refuse_a: assert property (qual && sleep_r |=> cyc_r == sfb_pkg::CYC_IDLE) // RULE15
    else $error("cycle started while asleep");

  deselect_power_a: assert property (qual && !advance_or_load // RULE15
    && !cs_all(chip_select_first_n, chip_select_second, chip_select_third_n) |=> power_down)
    else $error("not powered down while deselected");

  oe_read_a: assert property (qual && start && write_enable_n |=> dq_oe || output_enable_n) // RULE12
    else $error("read drivers not turned on by internal timing");

  step_idle_a: assert property (qual && advance_or_load && cyc_r == sfb_pkg::CYC_IDLE // RULE17
    |=> cyc_r == sfb_pkg::CYC_IDLE)
    else $error("advance started a cycle");

  burst_keep_a: assert property (qual && step |=> cyc_r == $past(cyc_r) // RULE17
    && addr_r[ADDR_W-1:2] == $past(addr_r[ADDR_W-1:2]))
    else $error("burst step changed operation or upper address");

  suspend_buffer_a: assert property (clock_qualify_n // RULE3
    |=> $stable(lanes_r) && $stable(base_lo_r) && $stable(write_buffer_ready))
    else $error("buffer or lanes moved while clock unqualified");

  write_read_c: cover property (qual && cyc_r == sfb_pkg::CYC_WRITE && start && write_enable_n);
  burst_c: cover property (qual && step ##1 qual && step ##1 qual && step);
  suspend_c: cover property (cyc_r == sfb_pkg::CYC_READ ##1 clock_qualify_n [*3]);
  buffer_full_c: cover property (!buf_in_ready);
  sleep_full_c: cover property (sleep_r && !buf_in_ready);

endmodule

// ===== sfb_ctrl_model.sv
`timescale 1ns/10ps

// ****************************************
// memory controller on the command bus
// ****************************************
module sfb_ctrl_model
(
  input  wire logic   sys_clk,
  output logic [15:0] address_upper,
  output logic        burst_address_bit1,
  output logic        burst_address_bit0,
  output logic        advance_or_load,
  output logic        write_enable_n,
  output logic [3:0]  byte_lane_write_select_n,
  output logic        chip_select_first_n,
  output logic        chip_select_second,
  output logic        chip_select_third_n,
  output logic        clock_qualify_n,
  output logic [35:0] dq_in
);
  logic        pend_w;
  logic [35:0] pend_d;

  initial
  begin
    {address_upper, burst_address_bit1, burst_address_bit0} = 18'h00000;
    advance_or_load          = 1'b0;
    write_enable_n           = 1'b1;
    byte_lane_write_select_n = 4'hF;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h6;
    clock_qualify_n          = 1'b0;
    dq_in                    = 36'h000000000;
    pend_w                   = 1'b0;
    pend_d                   = 36'h000000000;
  end

  // drive at a falling edge, return at the falling edge after the taking edge
  task automatic op(input logic adv, input logic we_n, input logic [17:0] a, input logic [3:0] ln,
                    input logic [35:0] wd, input logic [2:0] cs);
    {address_upper, burst_address_bit1, burst_address_bit0} = a;
    advance_or_load          = adv;
    write_enable_n           = we_n;
    byte_lane_write_select_n = ln;
    {chip_select_first_n, chip_select_second, chip_select_third_n} = cs;
    clock_qualify_n          = 1'b0;
    // a released data bus does not keep its last value
    dq_in                    = pend_w ? pend_d : ~dq_in;
    pend_w                   = !adv && !we_n;
    pend_d                   = wd;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  // suspended edges carry a changing write command that must be ignored
  task automatic hold(input int n);
    repeat (n)
    begin
      clock_qualify_n = 1'b1;
      write_enable_n  = 1'b0;
      address_upper   = ~address_upper;
      dq_in           = ~dq_in;
      @(posedge sys_clk);
      @(negedge sys_clk);
    end
  endtask
endmodule

// ===== tb_flow_through_sync_burst_sram_port.sv
`timescale 1ns/10ps

module tb_flow_through_sync_burst_sram_port;
  localparam logic [2:0] CS_ON = 3'h2;
  logic             sys_clk;
  logic             reset;
  logic             output_enable_n;
  logic             sleep_request;
  logic             burst_order_interleaved;
  wire logic [15:0] address_upper;
  wire logic        burst_address_bit1;
  wire logic        burst_address_bit0;
  wire logic        advance_or_load;
  wire logic        write_enable_n;
  wire logic [3:0]  byte_lane_write_select_n;
  wire logic        chip_select_first_n;
  wire logic        chip_select_second;
  wire logic        chip_select_third_n;
  wire logic        clock_qualify_n;
  wire logic [35:0] dq_in;
  logic      [35:0] dq_out;
  logic             dq_oe;
  logic             write_buffer_ready;
  logic             power_down;
  int               miscompares;
  int               total_checks;

  sfb_ctrl_model ctl (.sys_clk, .address_upper, .burst_address_bit1, .burst_address_bit0, .advance_or_load,
    .write_enable_n, .byte_lane_write_select_n, .chip_select_first_n, .chip_select_second,
    .chip_select_third_n, .clock_qualify_n, .dq_in);

  sfb_sram_port #(.NARROW_VARIANT(1'b0)) dut (.sys_clk, .reset, .address_upper, .burst_address_bit1,
    .burst_address_bit0, .advance_or_load, .write_enable_n, .byte_lane_write_select_n,
    .chip_select_first_n, .chip_select_second, .chip_select_third_n, .clock_qualify_n, .output_enable_n,
    .sleep_request, .burst_order_interleaved, .dq_in, .dq_out, .dq_oe, .write_buffer_ready, .power_down);

  // ****************************************
  // shared helpers
  // ****************************************
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    total_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic nop;
    ctl.op(1'b0, 1'b1, 18'h00000, 4'hF, 36'h000000000, 3'h6);
  endtask

  task automatic rd(input logic [17:0] a, input logic [35:0] d);
    ctl.op(1'b0, 1'b1, a, 4'hF, 36'h000000000, CS_ON);
    chk("dq_oe", 36'h1, {35'h0, dq_oe});
    chk("dq_out", d, dq_out);
    chk("power_down", 36'h0, {35'h0, power_down});
  endtask

  task automatic wr(input logic [17:0] a, input logic [3:0] ln, input logic [35:0] d);
    ctl.op(1'b0, 1'b0, a, ln, d, CS_ON);
    chk("dq_oe in write", 36'h0, {35'h0, dq_oe});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic s_turnaround;
    wr(18'h00010, 4'h0, 36'h123456789);
    wr(18'h00020, 4'h0, 36'hFEDCBA987);
    rd(18'h00010, 36'h123456789);
    wr(18'h00020, 4'hA, 36'h000000000);
    rd(18'h00020, 36'hFEDCBA987 & ~36'h007FC01FF);
    rd(18'h00010, 36'h123456789);
    chk("write_buffer_ready", 36'h1, {35'h0, write_buffer_ready});
  endtask

  task automatic s_qualify;
    rd(18'h00010, 36'h123456789);
    ctl.hold(3);
    chk("dq_oe frozen", 36'h1, {35'h0, dq_oe});
    chk("dq_out frozen", 36'h123456789, dq_out);
    wr(18'h00030, 4'h0, 36'h0A5A5A5A5);
    ctl.hold(2);
    rd(18'h00030, 36'h0A5A5A5A5);
  endtask

  task automatic s_selects;
    for (int i = 0; i < 3; i++)
    begin
      ctl.op(1'b0, 1'b1, 18'h00010, 4'hF, 36'h000000000, CS_ON ^ (3'h4 >> i));
      chk("dq_oe deselected", 36'h0, {35'h0, dq_oe});
      chk("power_down deselected", 36'h1, {35'h0, power_down});
    end
    ctl.op(1'b1, 1'b1, 18'h00010, 4'hF, 36'h000000000, CS_ON);
    chk("dq_oe advance idle", 36'h0, {35'h0, dq_oe});
  endtask

  task automatic s_oe;
    rd(18'h00010, 36'h123456789);
    output_enable_n = 1'b1;
    #2;
    chk("dq_oe gated", 36'h0, {35'h0, dq_oe});
    output_enable_n = 1'b0;
    #2;
    chk("dq_oe regated", 36'h1, {35'h0, dq_oe});
    @(negedge sys_clk);
  endtask

  task automatic s_burst;
    logic [1:0] low;
    for (int n = 0; n < 4; n++)
      wr({16'h0040, n[1:0]}, 4'h0, 36'h100 + n);
    for (int il = 0; il < 2; il++)
    begin
      burst_order_interleaved = il[0];
      nop();
      rd({16'h0040, 2'h1}, 36'h101);
      for (int k = 1; k < 4; k++)
      begin
        low = (il != 0) ? (2'h1 ^ k[1:0]) : (2'h1 + k[1:0]);
        ctl.op(1'b1, 1'b1, 18'h3FFFF, 4'hF, 36'h000000000, CS_ON);
        chk("burst data", 36'h100 + low, dq_out);
      end
    end
    burst_order_interleaved = 1'b0;
  endtask

  // sleep lands between two writes, so the second one fills the stalled buffer
  task automatic s_sleep;
    sleep_request = 1'b1;
    wr(18'h00050, 4'h0, 36'h111111111);
    wr(18'h00060, 4'h0, 36'h222222222);
    nop();
    chk("write_buffer_ready asleep", 36'h0, {35'h0, write_buffer_ready});
    repeat (3) nop();
    chk("power_down asleep", 36'h1, {35'h0, power_down});
    rd_refused();
    sleep_request = 1'b0;
    repeat (3) nop();
    rd(18'h00010, 36'h123456789);
    rd(18'h00050, 36'h111111111);
    rd(18'h00060, 36'h222222222);
  endtask

  task automatic rd_refused;
    ctl.op(1'b0, 1'b1, 18'h00010, 4'hF, 36'h000000000, CS_ON);
    chk("dq_oe asleep", 36'h0, {35'h0, dq_oe});
  endtask

  // ****************************************
  // clock, reset and sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  initial
  begin
    #400000;
    miscompares++;
    end_of_test();
  end

  initial
  begin
    miscompares             = 0;
    total_checks            = 0;
    reset                   = 1'b1;
    output_enable_n         = 1'b0;
    sleep_request           = 1'b0;
    burst_order_interleaved = 1'b0;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    chk("power_down after reset", 36'h1, {35'h0, power_down});
    chk("dq_oe after reset", 36'h0, {35'h0, dq_oe});
    s_turnaround();
    s_qualify();
    s_selects();
    s_oe();
    s_burst();
    s_sleep();
    end_of_test();
  end
endmodule
